//--- vps_pkg.sv
// Constants for the virtual PHY basic status register
package vps_pkg;
    // Memory-mapped byte offset and serial management index of the register
    localparam logic [8:0] VPS_STATUS_OFFSET = 9'h1c4;
    localparam logic [4:0] VPS_STATUS_INDEX = 5'h01;
    localparam logic [4:0] VPS_FIRST_INDEX = 5'h00;
    localparam logic [4:0] VPS_LAST_INDEX = 5'h06;

    // Bit positions inside the 16-bit status value
    localparam int VPS_BIT_EXT_CAP = 0;
    localparam int VPS_BIT_JABBER = 1;
    localparam int VPS_BIT_LINK_UP = 2;
    localparam int VPS_BIT_AN_ABLE = 3;
    localparam int VPS_BIT_REMOTE_FAULT = 4;
    localparam int VPS_BIT_AN_DONE = 5;
    localparam int VPS_BIT_EXT_STATUS = 8;
    localparam int VPS_BIT_10T_HD = 11;
    localparam int VPS_BIT_10T_FD = 12;
    localparam int VPS_BIT_100X_HD = 13;
    localparam int VPS_BIT_100X_FD = 14;
    localparam int VPS_BIT_100T4 = 15;

    // Fixed part of the status value; auto-negotiation complete and link up are merged in
    localparam logic [15:0] VPS_STATUS_FIXED = 16'h7809;
    localparam logic [15:0] VPS_PAD_ZERO = 16'h0000;

    // Emulated auto-negotiation run time after reset or restart
    localparam int VPS_CLK_PERIOD_NS = 40;
    localparam int VPS_AN_SETTLE_NS = 1000;
    localparam int VPS_AN_SETTLE_CYC_INT =
        (VPS_AN_SETTLE_NS + VPS_CLK_PERIOD_NS - 1) / VPS_CLK_PERIOD_NS;
    localparam logic [5:0] VPS_AN_SETTLE_CYC = 6'(VPS_AN_SETTLE_CYC_INT);
    localparam logic [5:0] VPS_CNT_ZERO = 6'h00;
    localparam logic [5:0] VPS_CNT_ONE = 6'h01;

    typedef enum logic [0:0] {
        VPS_AN_RUN,
        VPS_AN_COMPLETE
    } vps_an_state_t;
endpackage : vps_pkg

//--- vps_status.sv
// Virtual PHY basic status register with memory-mapped and serial read ports
// How it works
// - Jabber bit 1 always reads 0.
// - Extended capability bit 0 reads 1.
// - No remote fault; link always up.
// - Only management registers 0 to 6 exist.
// - 32-bit form pads 31:16; serial 16 bits.
// - Only 100BASE-X, 10BASE-T abilities; others 0.
// - Extended status / gigabit bit reads 0.
// - AN complete clears on reset, sets later.
// - Bit 2 link status, resets to 1.
`timescale 1ns/10ps
`default_nettype none
module vps_status (
    input wire logic CORE_CLK_I,
    input wire logic RESET_N_I,
    input wire logic AN_RESTART_I,
    input wire logic CSR_RD_I,
    input wire logic CSR_WR_I,
    input wire logic [8:0] CSR_ADDR_I,
    output logic [31:0] CSR_RDATA_O,
    output logic CSR_ACK_O,
    output logic CSR_HIT_O,
    input wire logic MII_RD_I,
    input wire logic [4:0] MII_REG_I,
    output logic [15:0] MII_RDATA_O,
    output logic MII_RVALID_O,
    output logic MII_IMPL_O,
    output logic AN_DONE_O
);
    vps_pkg::vps_an_state_t an_state_ff;
    vps_pkg::vps_an_state_t nxt_an_state;
    logic [5:0] an_cnt_ff;
    logic [5:0] nxt_an_cnt;
    logic an_done;
    wire logic [15:0] status_val;

    // Emulated negotiation: no link partner, so it simply completes after a delay
    always_comb begin
        nxt_an_state = an_state_ff;
        nxt_an_cnt = an_cnt_ff;
        case (an_state_ff)
            vps_pkg::VPS_AN_RUN: begin
                if (an_cnt_ff == vps_pkg::VPS_CNT_ONE) begin
                    nxt_an_state = vps_pkg::VPS_AN_COMPLETE;
                    nxt_an_cnt = vps_pkg::VPS_CNT_ZERO;
                end else begin
                    nxt_an_cnt = an_cnt_ff - vps_pkg::VPS_CNT_ONE;
                end
            end
            vps_pkg::VPS_AN_COMPLETE: begin
                nxt_an_cnt = vps_pkg::VPS_CNT_ZERO;
            end
            default: begin
                nxt_an_state = vps_pkg::VPS_AN_RUN;
                nxt_an_cnt = vps_pkg::VPS_AN_SETTLE_CYC;
            end
        endcase
        if (AN_RESTART_I) begin
            nxt_an_state = vps_pkg::VPS_AN_RUN;
            nxt_an_cnt = vps_pkg::VPS_AN_SETTLE_CYC;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            an_state_ff <= vps_pkg::VPS_AN_RUN;
            an_cnt_ff <= vps_pkg::VPS_AN_SETTLE_CYC;
        end else begin
            an_state_ff <= nxt_an_state;
            an_cnt_ff <= nxt_an_cnt;
        end
    end

    assign an_done = (an_state_ff == vps_pkg::VPS_AN_COMPLETE);

    // One cell per status bit; only AN complete is live, the rest are tied
    for (genvar b = 0; b < 16; b++) begin : g_status_bit
        if (b == vps_pkg::VPS_BIT_AN_DONE) begin : g_an_done
            assign status_val[b] = an_done;
        end else if (b == vps_pkg::VPS_BIT_LINK_UP) begin : g_link_up
            // No link partner to lose, so the link never drops
            assign status_val[b] = 1'b1;
        end else if (b == vps_pkg::VPS_BIT_REMOTE_FAULT) begin : g_no_fault
            assign status_val[b] = 1'b0;
        end else if (b == vps_pkg::VPS_BIT_JABBER) begin : g_no_jabber
            assign status_val[b] = 1'b0;
        end else if (b == vps_pkg::VPS_BIT_EXT_CAP) begin : g_ext_cap
            assign status_val[b] = 1'b1;
        end else if (b == vps_pkg::VPS_BIT_10T_HD ||
                     b == vps_pkg::VPS_BIT_10T_FD ||
                     b == vps_pkg::VPS_BIT_100X_HD ||
                     b == vps_pkg::VPS_BIT_100X_FD) begin : g_ability
            assign status_val[b] = vps_pkg::VPS_STATUS_FIXED[b];
        end else if (b == vps_pkg::VPS_BIT_AN_ABLE) begin : g_an_able
            assign status_val[b] = vps_pkg::VPS_STATUS_FIXED[b];
        end else if (b == vps_pkg::VPS_BIT_EXT_STATUS) begin : g_no_ext_status
            assign status_val[b] = 1'b0;
        end else if (b == vps_pkg::VPS_BIT_100T4) begin : g_no_t4
            assign status_val[b] = 1'b0;
        end else begin : g_reserved
            // Reserved bits between the abilities read zero
            assign status_val[b] = vps_pkg::VPS_STATUS_FIXED[b];
        end
    end

    // Memory-mapped port: acknowledge one cycle after any request
    logic csr_req;
    logic csr_sel;
    logic csr_rd_hit;
    logic csr_rd_miss;
    logic [31:0] csr_word;

    // Registered replies
    logic [31:0] csr_rdata_ff;
    logic [31:0] nxt_csr_rdata;
    logic csr_ack_ff;
    logic nxt_csr_ack;
    logic csr_hit_ff;
    logic nxt_csr_hit;

    always_comb begin
        csr_req = CSR_RD_I | CSR_WR_I;
        csr_sel = (CSR_ADDR_I == vps_pkg::VPS_STATUS_OFFSET);
        csr_rd_hit = CSR_RD_I & csr_sel;
        csr_rd_miss = CSR_RD_I & ~csr_sel;
        // Upper half is padding and always reads zero
        csr_word = {vps_pkg::VPS_PAD_ZERO, status_val};
        // Writes are acknowledged but change nothing: the register is read-only
        nxt_csr_ack = csr_req;
        nxt_csr_hit = csr_req & csr_sel;
        // Read data holds between reads, so a late host still sees it
        nxt_csr_rdata = csr_rdata_ff;
        if (csr_rd_hit) begin
            nxt_csr_rdata = csr_word;
        end else if (csr_rd_miss) begin
            // Unmapped offsets read zero rather than stale data
            nxt_csr_rdata = {vps_pkg::VPS_PAD_ZERO, vps_pkg::VPS_PAD_ZERO};
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            csr_rdata_ff <= 32'h00000000;
            csr_ack_ff <= 1'b0;
            csr_hit_ff <= 1'b0;
        end else begin
            csr_rdata_ff <= nxt_csr_rdata;
            csr_ack_ff <= nxt_csr_ack;
            csr_hit_ff <= nxt_csr_hit;
        end
    end

    // Serial port: same timing, 16-bit value only
    wire logic [31:0] mii_impl_map;
    logic mii_sel;
    logic mii_in_range;
    logic mii_rd_hit;
    logic mii_rd_miss;

    // Registered replies
    logic [15:0] mii_rdata_ff;
    logic [15:0] nxt_mii_rdata;
    logic mii_rvalid_ff;
    logic nxt_mii_rvalid;
    logic mii_impl_ff;
    logic nxt_mii_impl;

    // One flag per management index; only the basic set is present
    for (genvar r = 0; r < 32; r++) begin : g_impl_map
        if (r <= vps_pkg::VPS_LAST_INDEX) begin : g_present
            assign mii_impl_map[r] = 1'b1;
        end else begin : g_absent
            assign mii_impl_map[r] = 1'b0;
        end
    end

    always_comb begin
        mii_sel = (MII_REG_I == vps_pkg::VPS_STATUS_INDEX);
        mii_in_range = mii_impl_map[MII_REG_I];
        mii_rd_hit = MII_RD_I & mii_sel;
        mii_rd_miss = MII_RD_I & ~mii_sel;
        nxt_mii_rvalid = MII_RD_I;
        nxt_mii_impl = MII_RD_I & mii_in_range;
        nxt_mii_rdata = mii_rdata_ff;
        if (mii_rd_hit) begin
            // Serial form carries only the low 16 bits
            nxt_mii_rdata = status_val;
        end else if (mii_rd_miss) begin
            // Other registers of the set are served outside this block
            nxt_mii_rdata = vps_pkg::VPS_PAD_ZERO;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            mii_rdata_ff <= 16'h0000;
            mii_rvalid_ff <= 1'b0;
            mii_impl_ff <= 1'b0;
        end else begin
            mii_rdata_ff <= nxt_mii_rdata;
            mii_rvalid_ff <= nxt_mii_rvalid;
            mii_impl_ff <= nxt_mii_impl;
        end
    end

    // Replies come straight from registers
    assign CSR_RDATA_O = csr_rdata_ff;
    assign CSR_ACK_O = csr_ack_ff;
    assign CSR_HIT_O = csr_hit_ff;

    assign MII_RDATA_O = mii_rdata_ff;
    assign MII_RVALID_O = mii_rvalid_ff;
    assign MII_IMPL_O = mii_impl_ff;

    assign AN_DONE_O = an_done;
endmodule : vps_status
`default_nettype wire

//--- vps_status_assertions.sv
// Checker for the virtual PHY status register ports
`timescale 1ns/10ps
`default_nettype none
module vps_status_assertions (
    input wire logic CORE_CLK_I, RESET_N_I, AN_RESTART_I, CSR_RD_I, CSR_WR_I, CSR_ACK_O,
    input wire logic CSR_HIT_O, MII_RD_I, MII_RVALID_O, MII_IMPL_O, AN_DONE_O,
    input wire logic [8:0] CSR_ADDR_I,
    input wire logic [31:0] CSR_RDATA_O,
    input wire logic [4:0] MII_REG_I,
    input wire logic [15:0] MII_RDATA_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    sequence an_run;
        !AN_DONE_O [*8];
    endsequence
    a_ack_follows: assert property ((CSR_RD_I || CSR_WR_I) |=> CSR_ACK_O) else $error("no ack");
    a_hit_decode: assert property (CSR_RD_I |=> CSR_HIT_O == ($past(CSR_ADDR_I) == 9'h1c4))
        else $error("bad hit");
    a_pad_zero: assert property (CSR_ACK_O |-> CSR_RDATA_O[31:16] == 16'h0000) else $error("pad");
    a_csr_value: assert property ($past(CSR_RD_I) && CSR_HIT_O |->
        CSR_RDATA_O == {26'h00001e0, $past(AN_DONE_O), 5'h0d}) else $error("csr value");
    a_mii_value: assert property (MII_RD_I && MII_REG_I == 5'h01 |=>
        MII_RDATA_O == {10'h1e0, $past(AN_DONE_O), 5'h0d}) else $error("mii value");
    a_mii_other: assert property (MII_RD_I && MII_REG_I != 5'h01 |=> MII_RDATA_O == 16'h0000)
        else $error("other index");
    a_impl_range: assert property (MII_RD_I |=> MII_RVALID_O && MII_IMPL_O == ($past(MII_REG_I) <= 5'h06))
        else $error("impl");
    a_an_reset: assert property ($rose(RESET_N_I) |-> an_run ##[16:19] AN_DONE_O) else $error("an");
    a_an_restart: assert property (AN_RESTART_I |=> an_run ##[15:18] AN_DONE_O) else $error("rst");
endmodule : vps_status_assertions
`default_nettype wire

//--- vps_mii_host.sv
// Serial management master model reading the virtual PHY
`timescale 1ns/10ps
`default_nettype none
module vps_mii_host (
    input wire logic CORE_CLK_I, MII_RVALID_O, MII_IMPL_O,
    input wire logic [15:0] MII_RDATA_O,
    output var logic MII_RD_I = 1'b0,
    output var logic [4:0] MII_REG_I = 5'h00
);
    // Index scrambled once released so stale values never look valid
    task automatic rd(input logic [4:0] idx, output logic [15:0] data, output logic impl,
                      output logic vld);
        @(posedge CORE_CLK_I);
        MII_RD_I <= 1'b1;
        MII_REG_I <= idx;
        @(posedge CORE_CLK_I);
        MII_RD_I <= 1'b0;
        MII_REG_I <= ~idx;
        #1 data = MII_RDATA_O;
        impl = MII_IMPL_O;
        vld = MII_RVALID_O;
    endtask : rd
endmodule : vps_mii_host
`default_nettype wire

//--- vps_status_tb.sv
// Self-checking bench for the virtual PHY status register
`timescale 1ns/10ps
`default_nettype none
module vps_status_tb;
    logic CORE_CLK_I = 1'b0, RESET_N_I = 1'b0, AN_RESTART_I = 1'b0, CSR_RD_I = 1'b0, CSR_WR_I = 1'b0;
    logic [8:0] CSR_ADDR_I = 9'h000;
    wire logic [31:0] CSR_RDATA_O;
    wire logic [15:0] MII_RDATA_O;
    wire logic [4:0] MII_REG_I;
    wire logic CSR_ACK_O, CSR_HIT_O, MII_RD_I, MII_RVALID_O, MII_IMPL_O, AN_DONE_O;
    int err_total = 0, checks = 0;
    logic [31:0] d;
    logic [15:0] m;
    logic h, v;
    vps_status vps_status_i (.*);
    vps_mii_host vps_mii_host_i (.*);
    initial forever #20 CORE_CLK_I = ~CORE_CLK_I;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test;
        if (err_total == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    task automatic csr(input logic w, input logic [8:0] a);
        @(posedge CORE_CLK_I);
        CSR_RD_I <= !w;
        CSR_WR_I <= w;
        CSR_ADDR_I <= a;
        @(posedge CORE_CLK_I);
        CSR_RD_I <= 1'b0;
        CSR_WR_I <= 1'b0;
        #1 d = CSR_RDATA_O;
        h = CSR_HIT_O;
        chk(CSR_ACK_O, 1);
    endtask : csr
    task automatic wait_an;
        for (int i = 0; i < 40 && AN_DONE_O !== 1'b1; i++) @(posedge CORE_CLK_I);
        chk(AN_DONE_O, 1);
        if (AN_DONE_O !== 1'b1) end_of_test;
    endtask : wait_an
    task automatic t_reset_an;
        chk(AN_DONE_O, 0);
        csr(1'b0, 9'h1c4);
        chk(d, 32'h0000780d);
        chk(h, 1);
        wait_an;
        csr(1'b0, 9'h1c4);
        chk(d, 32'h0000782d);
    endtask : t_reset_an
    task automatic t_write_unmapped;
        csr(1'b1, 9'h1c4);
        csr(1'b0, 9'h1c4);
        chk(d, 32'h0000782d);
        csr(1'b0, 9'h1c8);
        chk(d, 0);
        chk(h, 0);
    endtask : t_write_unmapped
    task automatic t_mii;
        logic [4:0] idx;
        for (int i = 0; i < 9; i++) begin
            idx = (i == 8) ? 5'h1f : 5'(i);
            vps_mii_host_i.rd(idx, m, h, v);
            chk(v, 1);
            chk(m, idx == 5'h01 ? 32'h0000782d : 32'h0);
            chk(h, idx <= 5'h06);
        end
    endtask : t_mii
    task automatic t_restart;
        @(posedge CORE_CLK_I);
        AN_RESTART_I <= 1'b1;
        @(posedge CORE_CLK_I);
        AN_RESTART_I <= 1'b0;
        #1 chk(AN_DONE_O, 0);
        csr(1'b0, 9'h1c4);
        chk(d, 32'h0000780d);
        wait_an;
    endtask : t_restart
    initial begin
        repeat (10) @(posedge CORE_CLK_I);
        RESET_N_I <= 1'b1;
        t_reset_an;
        t_write_unmapped;
        t_mii;
        t_restart;
        end_of_test;
    end
endmodule : vps_status_tb
bind vps_status vps_status_assertions vps_status_assertions_i (.*);
`default_nettype wire
